// *** hdl/divcfg_regs.sv ***
// Channel vector map registers and config target registers.
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
module divcfg_regs (
    input  wire logic                            core_clk,
    input  wire logic                            rst,
    input  wire logic [divcfg_pkg::TGT_W-1:0]    reg_target,
    input  wire logic [divcfg_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [31:0]                     reg_wdata,
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    output logic [31:0]                          reg_rdata,
    input  wire logic [15:0]                     link_bdf,
    input  wire logic [2:0]                      link_neg_payload,
    input  wire logic [2:0]                      link_neg_read,
    input  wire logic                            link_msi_en,
    input  wire logic                            link_msix_en,
    input  wire logic [2:0]                      host_to_card_channel_count,
    input  wire logic                            chan_irq,
    input  wire logic [divcfg_pkg::SLOT_W-1:0]   chan_irq_slot,
    input  wire logic                            chan_irq_is_c2h,
    output logic                                 irq_msg_valid,
    output logic [divcfg_pkg::VEC_W-1:0]         irq_msg_vector,
    output logic [3:0]                           irq_legacy_line,
    output logic                                 relaxed_order,
    output logic [2:0]                           user_eff_payload,
    output logic [2:0]                           user_eff_read,
    output logic [4:0]                           flush_timeout
);
    import divcfg_pkg::*;

    // ==========================================================
    // Address decode
    // ==========================================================
    logic                           sel_irq;
    logic                           sel_cfg;
    logic [VEC_W-1:0]               vec [NUM_SLOTS];
    logic [SIZE_W-1:0]              user_prg_payload;
    logic [SIZE_W-1:0]              user_prg_read;
    logic [SLOT_W-1:0]              slot_idx;
    logic [SIZE_W-1:0]              link_payload;
    logic [SIZE_W-1:0]              link_read;
    logic [31:0]                    next_rdata;

    assign sel_irq = (reg_target == TGT_IRQ);
    assign sel_cfg = (reg_target == TGT_CONFIG); // RULE7

    // ==========================================================
    // Channel vector map
    // ==========================================================
    genvar g;
    generate
        for (g = 0; g < NUM_SLOTS; g++) begin : g_vec
            localparam logic [11:0] OFS =
                (g < FIELDS_PER_REG) ? OFS_VEC_LO : OFS_VEC_HI; // RULE3
            localparam int LSB = (g % FIELDS_PER_REG) * FIELD_STRIDE;
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    vec[g] <= VEC_RST; // RULE2
                end else if (reg_wr && sel_irq && reg_addr == OFS) begin
                    vec[g] <= reg_wdata[LSB +: VEC_W]; // RULE2
                end
            end
        end
    endgenerate

    // ==========================================================
    // Channel interrupt vector delivery
    // ==========================================================
    // Card-to-host channel n uses slot host_to_card_channel_count + n, counting on from the last host-to-card one.
    assign slot_idx = chan_irq_is_c2h ?
        SLOT_W'(host_to_card_channel_count + chan_irq_slot) :
        chan_irq_slot; // RULE5 RULE6

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_msg_valid   <= 1'b0;
            irq_msg_vector  <= VEC_RST;
            irq_legacy_line <= 4'h0;
        end else begin
            irq_msg_valid   <= chan_irq && (link_msi_en || link_msix_en);
            irq_msg_vector  <= vec[slot_idx]; // RULE1
            irq_legacy_line <= 4'h0;
            if (chan_irq && !(link_msi_en || link_msix_en)) begin
                irq_legacy_line[vec[slot_idx][LEGACY_W-1:0]] <= 1'b1; // RULE4
            end
        end
    end

    // ==========================================================
    // Config target writable registers
    // ==========================================================
    always_ff @(posedge core_clk) begin
        if (rst) begin
            relaxed_order <= RELAXED_RST;
        end else if (reg_wr && sel_cfg && reg_addr == OFS_CONTROL) begin
            relaxed_order <= reg_wdata[0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            user_prg_payload <= USER_SIZE_RST;
            user_prg_read    <= USER_SIZE_RST;
        end else if (reg_wr && sel_cfg) begin
            if (reg_addr == OFS_USER_PAY) begin
                user_prg_payload <= (reg_wdata[2:0] > SIZE_MAX_CODE) ?
                    SIZE_MAX_CODE : reg_wdata[2:0];
            end
            if (reg_addr == OFS_USER_READ) begin
                user_prg_read <= (reg_wdata[2:0] > SIZE_MAX_CODE) ?
                    SIZE_MAX_CODE : reg_wdata[2:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            flush_timeout <= FLUSH_RST;
        end else if (reg_wr && sel_cfg && reg_addr == OFS_FLUSH) begin
            flush_timeout <= reg_wdata[4:0];
        end
    end

    // ==========================================================
    // Derived link sizes
    // ==========================================================
    assign link_payload = (link_neg_payload < CFG_PAYLOAD_LIM) ?
        link_neg_payload : CFG_PAYLOAD_LIM; // RULE10 RULE14
    assign link_read = (link_neg_read < CFG_READ_LIM) ?
        link_neg_read : CFG_READ_LIM; // RULE11

    always_ff @(posedge core_clk) begin
        if (rst) begin
            user_eff_payload <= USER_SIZE_RST;
            user_eff_read    <= USER_SIZE_RST;
        end else begin
            user_eff_payload <= (user_prg_payload < link_payload) ?
                user_prg_payload : link_payload;
            user_eff_read <= (user_prg_read < link_read) ?
                user_prg_read : link_read;
        end
    end

    // ==========================================================
    // Read mux
    // ==========================================================
    always_comb begin
        next_rdata = ZERO_WORD; // RULE14
        if (sel_irq) begin
            for (int i = 0; i < FIELDS_PER_REG; i++) begin
                if (reg_addr == OFS_VEC_LO) begin
                    next_rdata[i*FIELD_STRIDE +: VEC_W] = vec[i];
                end else if (reg_addr == OFS_VEC_HI) begin
                    next_rdata[i*FIELD_STRIDE +: VEC_W] =
                        vec[i+FIELDS_PER_REG];
                end
            end
        end else if (sel_cfg) begin
            case (reg_addr) // RULE13
                OFS_IDENTITY: begin
                    next_rdata = {SUBSYS_CODE, TARGET_CODE, 8'h00,
                                  RELEASE_CODE}; // RULE8
                end
                OFS_BDF: begin
                    next_rdata[15:0] = link_bdf; // RULE9
                end
                OFS_MAX_PAYLOAD: begin
                    next_rdata[2:0] = link_payload; // RULE10
                end
                OFS_MAX_READ: begin
                    next_rdata[2:0] = link_read; // RULE11
                end
                OFS_SYSTEM: begin
                    next_rdata[15:0] = CORE_SYSTEM_CODE; // RULE12
                end
                OFS_MSI_EN: begin
                    next_rdata[1:0] = {link_msix_en, link_msi_en};
                end
                OFS_DATA_WIDTH: begin
                    next_rdata[2:0] = DATA_WIDTH_CODE;
                end
                OFS_CONTROL: begin
                    next_rdata[0] = relaxed_order;
                end
                OFS_USER_PAY: begin
                    next_rdata[6:0] = {user_eff_payload, 1'b0,
                                       user_prg_payload};
                end
                OFS_USER_READ: begin
                    next_rdata[6:0] = {user_eff_read, 1'b0, user_prg_read};
                end
                OFS_FLUSH: begin
                    next_rdata[4:0] = flush_timeout;
                end
                default: begin
                    next_rdata = ZERO_WORD;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= ZERO_WORD;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= ZERO_WORD;
        end
    end
endmodule

// *** hdl/divcfg_pkg.sv ***
// Package with register map, field layout and constants for the vector/config bank.
// Function
// RULE1 - With message interrupts enabled each channel interrupt carries the vector from its mapping field.
// RULE2 - The low vector register holds four 5-bit read-write fields for slots 0 to 3 at bits 4:0, 12:8, 20:16, 28:24, reset to zero.
// RULE3 - The high vector register at the next word holds slots 4 to 7 at the same field positions.
// RULE4 - In legacy mode only the two low bits of a field pick one of the four legacy lines.
// RULE5 - Slots hold host-to-card channels first, and card-to-host channels follow the last of them.
// RULE6 - With four host-to-card channels card-to-host 0 is slot 4, with one it is slot 1.
// RULE7 - The config registers are reached as register target 3.
// RULE8 - The identity register is read-only with subsystem, target and version codes and reserved bits 15:8.
// RULE9 - The bus-device register shows the endpoint's bus, device and function number from the core.
// RULE10 - The link payload field reports the smaller of the negotiated and configured payload sizes.
// RULE11 - The read request field reports the smaller of the negotiated and configured limits, coded 0 to 5.
// RULE12 - The system code register returns a fixed 16-bit code and ignores writes.
// RULE13 - The config target also decodes registers at 0x14, 0x18, 0x1C, 0x40, 0x44 and 0x60.
// RULE14 - The payload field uses the doubling code and reserved or unmapped bits read zero.
package divcfg_pkg;
    localparam int          ADDR_W          = 12;
    localparam int          TGT_W           = 4;
    localparam int          NUM_SLOTS       = 8;
    localparam int          VEC_W           = 5;
    localparam int          SIZE_W          = 3;
    localparam int          SLOT_W          = 3;
    localparam int          FIELD_STRIDE    = 8;
    localparam int          FIELDS_PER_REG  = 4;
    localparam int          LEGACY_W        = 2;
    // Register targets within the subsystem space.
    localparam logic [3:0]  TGT_IRQ         = 4'h2;
    localparam logic [3:0]  TGT_CONFIG      = 4'h3;
    // Offsets.
    localparam logic [11:0] OFS_VEC_LO      = 12'h0A0;
    localparam logic [11:0] OFS_VEC_HI      = 12'h0A4;
    localparam logic [11:0] OFS_IDENTITY    = 12'h000;
    localparam logic [11:0] OFS_BDF         = 12'h004;
    localparam logic [11:0] OFS_MAX_PAYLOAD = 12'h008;
    localparam logic [11:0] OFS_MAX_READ    = 12'h00C;
    localparam logic [11:0] OFS_SYSTEM      = 12'h010;
    localparam logic [11:0] OFS_MSI_EN      = 12'h014;
    localparam logic [11:0] OFS_DATA_WIDTH  = 12'h018;
    localparam logic [11:0] OFS_CONTROL     = 12'h01C;
    localparam logic [11:0] OFS_USER_PAY    = 12'h040;
    localparam logic [11:0] OFS_USER_READ   = 12'h044;
    localparam logic [11:0] OFS_FLUSH       = 12'h060;
    // Identity fields and system code; the code values are arbitrary.
    localparam logic [11:0] SUBSYS_CODE     = 12'hA5C;
    localparam logic [3:0]  TARGET_CODE     = TGT_CONFIG;
    localparam logic [7:0]  RELEASE_CODE    = 8'h10;
    localparam logic [15:0] CORE_SYSTEM_CODE = 16'h5A5A;
    // Reset values, size limits and fixed codes.
    localparam logic [4:0]  VEC_RST         = 5'h00;
    localparam logic [2:0]  USER_SIZE_RST   = 3'h5;
    localparam logic        RELAXED_RST     = 1'b1;
    localparam logic [4:0]  FLUSH_RST       = 5'h00;
    localparam logic [2:0]  SIZE_MAX_CODE   = 3'h5;
    localparam logic [2:0]  CFG_PAYLOAD_LIM = 3'h5;
    localparam logic [2:0]  CFG_READ_LIM    = 3'h5;
    localparam logic [2:0]  DATA_WIDTH_CODE = 3'h1;
    localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
endpackage

// *** dv/divcfg_regs_monitor.sv ***
// Port checker for the vector map and config register bank.
`timescale 1ns/100ps
module divcfg_regs_monitor (
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    input  wire logic [divcfg_pkg::TGT_W-1:0]  reg_target,
    input  wire logic [divcfg_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic                          reg_rd,
    input  wire logic [31:0]                   reg_rdata,
    input  wire logic [15:0]                   link_bdf,
    input  wire logic [2:0]                    link_neg_payload,
    input  wire logic [2:0]                    link_neg_read,
    input  wire logic                          link_msi_en,
    input  wire logic                          link_msix_en,
    input  wire logic                          chan_irq,
    input  wire logic                          irq_msg_valid,
    input  wire logic [3:0]                    irq_legacy_line
);
    import divcfg_pkg::*;
    logic cfg_rd;
    logic msg_on;
    assign cfg_rd = reg_rd && reg_target == TGT_CONFIG;
    assign msg_on = link_msi_en || link_msix_en;
    function automatic logic [2:0] lesser(input logic [2:0] a, b);
        return a < b ? a : b;
    endfunction
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ==========================================
    // Register reads
    rdata_idle_a: assert property (
        !reg_rd |=> reg_rdata == ZERO_WORD)
        else $error("read data not zero outside a read");
    ident_read_a: assert property (
        cfg_rd && reg_addr == OFS_IDENTITY |=>
        reg_rdata == {SUBSYS_CODE, TARGET_CODE, 8'h00, RELEASE_CODE})
        else $error("identity word wrong");
    bdf_read_a: assert property (
        cfg_rd && reg_addr == OFS_BDF |=>
        reg_rdata == {16'h0000, $past(link_bdf)}) else $error("bdf wrong");
    payload_min_a: assert property (
        cfg_rd && reg_addr == OFS_MAX_PAYLOAD |=>
        reg_rdata == {29'h0, lesser($past(link_neg_payload),
                                    CFG_PAYLOAD_LIM)})
        else $error("payload field wrong");
    read_min_a: assert property (
        cfg_rd && reg_addr == OFS_MAX_READ |=>
        reg_rdata == {29'h0, lesser($past(link_neg_read), CFG_READ_LIM)})
        else $error("read request field wrong");
    sys_code_a: assert property (
        cfg_rd && reg_addr == OFS_SYSTEM |=>
        reg_rdata == {16'h0000, CORE_SYSTEM_CODE}) else $error("system code");
    // ==========================================
    // Interrupt issue
    msg_pulse_a: assert property (
        chan_irq && msg_on |=> irq_msg_valid && irq_legacy_line == 4'h0)
        else $error("message irq missing");
    legacy_line_a: assert property (
        chan_irq && !msg_on |=> !irq_msg_valid && $onehot(irq_legacy_line))
        else $error("legacy line wrong");
    irq_quiet_a: assert property (
        !chan_irq |=> !irq_msg_valid && irq_legacy_line == 4'h0)
        else $error("irq without event");
    cover property (chan_irq && link_msix_en && !link_msi_en);
    cover property (chan_irq && !msg_on);
    cover property (reg_rd && reg_target == TGT_IRQ);
endmodule

// *** dv/divcfg_regs_bench.sv ***
// Self-checking bench for the vector map and config register bank.
`timescale 1ns/100ps
module divcfg_regs_bench;
    import divcfg_pkg::*;
    logic        core_clk, rst, reg_wr, reg_rd, chan_irq, chan_irq_is_c2h;
    logic        link_msi_en, link_msix_en, irq_msg_valid, relaxed_order, rd_d;
    logic [3:0]  reg_target, irq_legacy_line;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, w;
    logic [15:0] link_bdf;
    logic [2:0]  link_neg_payload, link_neg_read, host_to_card_channel_count;
    logic [2:0]  chan_irq_slot, user_eff_payload, user_eff_read;
    logic [4:0]  irq_msg_vector, flush_timeout;
    logic [4:0]  vecs [8];
    logic [31:0] rq [$];
    logic [9:0]  iq [$];
    int          mismatches, comparisons;
    divcfg_regs dut (.core_clk, .rst, .reg_target, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .link_bdf, .link_neg_payload,
        .link_neg_read, .link_msi_en, .link_msix_en, .chan_irq,
        .host_to_card_channel_count, .chan_irq_slot, .chan_irq_is_c2h,
        .irq_msg_valid, .irq_msg_vector, .irq_legacy_line, .relaxed_order,
        .user_eff_payload, .user_eff_read, .flush_timeout);
    // ==========================================
    // Checking and driving tasks
    task automatic chk(input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // A read notes its expected word; a write uses d as data.
    task automatic bus(input logic wr, input logic [3:0] t,
                       input logic [11:0] a, input logic [31:0] d);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_target <= t;
        reg_addr <= a;
        reg_wdata <= d;
        if (!wr) rq.push_back(d);
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic irq(input logic c2h, input logic [2:0] s);
        logic [2:0] k;
        k = c2h ? s + host_to_card_channel_count : s;
        chan_irq <= 1'b1;
        chan_irq_is_c2h <= c2h;
        chan_irq_slot <= s;
        if (link_msi_en || link_msix_en) iq.push_back({1'b1, vecs[k], 4'h0});
        else iq.push_back({6'h00, 4'(4'h1 << vecs[k][1:0])});
        @(posedge core_clk);
        chan_irq <= 1'b0;
        @(posedge core_clk);
    endtask
    // ==========================================
    // Output watcher
    always @(posedge core_clk) rd_d <= reg_rd;
    always @(negedge core_clk) begin
        if (rd_d) chk(reg_rdata, rq.size() != 0 ? rq.pop_front() : 32'hX);
        if (irq_msg_valid || irq_legacy_line != 4'h0)
            chk({irq_msg_valid, irq_msg_valid ? {irq_msg_vector, 4'h0} :
                {5'h00, irq_legacy_line}}, iq.size() != 0 ? iq.pop_front()
                : 10'hX);
    end
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        tally_and_finish();
    end
    // ==========================================
    // Main sequence
    initial begin
        {reg_wr, reg_rd, chan_irq, chan_irq_is_c2h, chan_irq_slot} = '0;
        {reg_target, reg_addr, reg_wdata, link_msix_en} = '0;
        {rst, link_msi_en, host_to_card_channel_count} = {2'b11, 3'h4};
        void'($urandom(34));
        link_bdf = 16'($urandom);
        link_neg_payload = 3'($urandom % 6);
        link_neg_read = 3'($urandom % 6);
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        bus(0, TGT_CONFIG, OFS_IDENTITY, {SUBSYS_CODE, TARGET_CODE, 8'h00,
            RELEASE_CODE});
        bus(1, TGT_CONFIG, OFS_SYSTEM, 32'hFFFF_FFFF);
        bus(0, TGT_CONFIG, OFS_SYSTEM, {16'h0000, CORE_SYSTEM_CODE});
        bus(0, TGT_CONFIG, OFS_BDF, {16'h0000, link_bdf});
        bus(0, TGT_IRQ, OFS_VEC_LO, ZERO_WORD);
        bus(0, TGT_IRQ, OFS_VEC_HI, ZERO_WORD);
        bus(0, TGT_CONFIG, OFS_MSI_EN, 32'h1);
        bus(0, TGT_CONFIG, OFS_DATA_WIDTH, {29'h0, DATA_WIDTH_CODE});
        bus(0, TGT_CONFIG, OFS_CONTROL, 32'h1);
        bus(0, TGT_CONFIG, OFS_FLUSH, ZERO_WORD);
        bus(0, TGT_CONFIG, 12'h020, ZERO_WORD);
        bus(0, 4'h1, OFS_IDENTITY, ZERO_WORD);
        for (int c = 0; c < 6; c++) begin
            link_neg_payload <= 3'(c);
            link_neg_read <= 3'(5 - c);
            @(posedge core_clk);
            bus(0, TGT_CONFIG, OFS_MAX_PAYLOAD, 32'(c));
            bus(0, TGT_CONFIG, OFS_MAX_READ, 32'(5 - c));
        end
        bus(1, TGT_CONFIG, OFS_USER_PAY, 32'h2);
        bus(1, TGT_CONFIG, OFS_USER_READ, 32'h7);
        bus(1, TGT_CONFIG, OFS_FLUSH, 32'hFFFF_FFFF);
        bus(1, TGT_CONFIG, OFS_CONTROL, ZERO_WORD);
        bus(0, TGT_CONFIG, OFS_USER_PAY, 32'h22);
        bus(0, TGT_CONFIG, OFS_USER_READ, 32'h05);
        bus(0, TGT_CONFIG, OFS_FLUSH, 32'h1F);
        chk({user_eff_payload, user_eff_read, flush_timeout, relaxed_order},
            {3'h2, 3'h0, 5'h1F, 1'b0});
        for (int r = 0; r < 2; r++) begin
            w = $urandom;
            for (int k = 0; k < 4; k++) vecs[4 * r + k] = w[8 * k +: 5];
            bus(1, TGT_IRQ, r ? OFS_VEC_HI : OFS_VEC_LO, w);
            bus(0, TGT_IRQ, r ? OFS_VEC_HI : OFS_VEC_LO,
                w & 32'h1F1F_1F1F);
        end
        for (int m = 0; m < 6; m++) begin
            link_msi_en <= m % 3 == 0;
            link_msix_en <= m % 3 == 1;
            host_to_card_channel_count <= m < 3 ? 3'h1 : 3'h4;
            @(posedge core_clk);
            irq(1'b0, 3'(m % 4));
            irq(1'b1, 3'h0);
            irq(1'b1, 3'(m % 4));
        end
        repeat (4) @(posedge core_clk);
        chk(32'(rq.size() + iq.size()), ZERO_WORD);
        tally_and_finish();
    end
endmodule
bind divcfg_regs divcfg_regs_monitor mon (.core_clk, .rst, .reg_target,
    .reg_addr, .reg_rd, .reg_rdata, .link_bdf, .link_neg_payload,
    .link_neg_read, .link_msi_en, .link_msix_en, .chan_irq, .irq_msg_valid,
    .irq_legacy_line);
